// File: src/fdc_port_pkg.sv
package fdc_port_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// printed offsets are register indices; byte address is index times four
	localparam logic [9:0] IDX_STATUS = 10'h3F4;
	localparam logic [9:0] IDX_DATA = 10'h3F5;
	localparam logic [9:0] IDX_DIGITAL = 10'h3F7;
	localparam logic [9:0] IDX_CTRL = 10'h3F8;
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [11:0] ADDR_DATA = {IDX_DATA, 2'h0};
	localparam logic [11:0] ADDR_DIGITAL = {IDX_DIGITAL, 2'h0};
	localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_1M = 2'h3;
	localparam logic [1:0] RATE_RESET = RATE_250K;
	localparam logic [2:0] PRECOMP_RESET = 3'h0;
	localparam logic DENSITY_RESET = 1'b1;
	localparam logic [3:0] EXT_FILL = 4'hF;
	localparam int ST_DRV_A = 0;
	localparam int ST_DRV_B = 1;
	localparam int ST_CMD_BUSY = 4;
	localparam int ST_NON_DMA = 5;
	localparam int ST_DIR = 6;
	localparam int ST_RQM = 7;
	localparam int DSR_PRECOMP_LSB = 2;
	localparam int DSR_LOW_POWER = 6;
	localparam int DSR_SOFT_RESET = 7;
	localparam int CCR_NO_SHIFT = 2;
	localparam int CTL_LAYOUT_LSB = 0;
	localparam int CTL_FORCE_EN = 2;
	localparam int CTL_FORCE_VAL = 3;
	localparam logic [1:0] LAYOUT_AT = 2'h0;
	localparam logic [1:0] LAYOUT_EXT = 2'h1;
	localparam logic [1:0] LAYOUT_MIRROR = 2'h2;
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fdc_port_pkg

// File: src/bit_sync2.sv
`timescale 1ns/1ns
module bit_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_reg;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			meta_reg <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule : bit_sync2

// File: src/axil_reg_slave.sv
`timescale 1ns/1ns
module axil_reg_slave #(
	parameter int AW = fdc_port_pkg::ADDR_W
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [AW-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [AW-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_wr_en,
	output logic [AW-1:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	output logic [3:0] o_wr_strb,
	input wire logic i_wr_ok,
	output logic o_rd_en,
	output logic [AW-1:0] o_rd_addr,
	input wire logic [31:0] i_rd_data,
	input wire logic i_rd_ok
);
	// ready flags double as "holding slot empty"
	logic wr_fire;

	assign wr_fire = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
	assign o_wr_en = wr_fire;
	assign o_rd_en = i_s_axi_arvalid && o_s_axi_arready;
	assign o_rd_addr = i_s_axi_araddr;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_s_axi_awready <= 1'b1;
			o_wr_addr <= '0;
		end else if (i_s_axi_awvalid && o_s_axi_awready) begin
			o_s_axi_awready <= 1'b0;
			o_wr_addr <= i_s_axi_awaddr;
		end else if (wr_fire) begin
			o_s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_s_axi_wready <= 1'b1;
			o_wr_data <= '0;
			o_wr_strb <= '0;
		end else if (i_s_axi_wvalid && o_s_axi_wready) begin
			o_s_axi_wready <= 1'b0;
			o_wr_data <= i_s_axi_wdata;
			o_wr_strb <= i_s_axi_wstrb;
		end else if (wr_fire) begin
			o_s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= fdc_port_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= i_wr_ok ? fdc_port_pkg::RESP_OKAY
				: fdc_port_pkg::RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// one read outstanding; data captured at the address handshake
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= '0;
			o_s_axi_rresp <= fdc_port_pkg::RESP_OKAY;
		end else if (o_rd_en) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata <= i_rd_data;
			o_s_axi_rresp <= i_rd_ok ? fdc_port_pkg::RESP_OKAY
				: fdc_port_pkg::RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
		end
	end
endmodule : axil_reg_slave

// File: src/floppy_host_status_port.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module floppy_host_status_port #(
	parameter int FIFO_DEPTH = fdc_port_pkg::FIFO_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [11:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [11:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic i_media_changed_pin,
	input wire logic i_drive_a_seeking,
	input wire logic i_drive_b_seeking,
	input wire logic i_transfer_direction,
	input wire logic i_core_accept,
	input wire logic i_cmd_end,
	input wire logic i_exec_start,
	input wire logic i_exec_phase,
	input wire logic i_fifo_config,
	input wire logic i_fifo_enable,
	input wire logic [3:0] i_fifo_threshold,
	input wire logic i_core_push,
	input wire logic [7:0] i_core_push_data,
	input wire logic i_core_pop,
	input wire logic i_dor_reset,
	input wire logic i_dma_allow,
	output logic [7:0] o_core_pop_data,
	output logic o_core_pop_strobe,
	output logic o_xfer_fault,
	output logic [$clog2(FIFO_DEPTH):0] o_fifo_level,
	output logic o_fifo_on,
	output logic o_service_req,
	output logic o_cmd_busy,
	output logic o_soft_reset,
	output logic [1:0] o_rate_select,
	output logic [2:0] o_precomp,
	output logic o_no_write_shift,
	output logic o_low_power,
	output logic o_density_select_pin
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam logic [PTR_W:0] DEPTH_L = (PTR_W+1)'(FIFO_DEPTH);
	localparam logic [PTR_W:0] ONE_L = (PTR_W+1)'(1);

	// 500K and 1M run high density; 250K and 300K do not
	function automatic logic high_density(input logic [1:0] rate);
		return rate == fdc_port_pkg::RATE_500K
			|| rate == fdc_port_pkg::RATE_1M;
	endfunction : high_density

	logic wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic changed_pin_sync;

	logic [1:0] rate_reg;
	logic [2:0] precomp_reg;
	logic no_shift_reg;
	logic low_power_reg;
	logic density_reg;
	logic busy_reg;
	logic fifo_on_reg;
	logic [3:0] thr_reg;
	logic fault_reg;
	logic [3:0] ctrl_reg;
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] level_reg;
	logic [7:0] mem [FIFO_DEPTH];

	logic wr_lane;
	logic wr_status;
	logic wr_data_hit;
	logic wr_digital;
	logic wr_ctrl;
	logic rd_status;
	logic rd_data_hit;
	logic soft_rst;
	logic host_transfer_request;
	logic transfer_direction;
	logic [PTR_W:0] limit;
	logic full;
	logic empty;
	logic host_push;
	logic host_pop;
	logic core_push_ok;
	logic core_pop_ok;
	logic push;
	logic pop;
	logic flush;
	logic [7:0] push_data;
	logic [7:0] status;
	logic [7:0] digital;
	logic [1:0] layout;
	logic change_bit;
	logic rate_write;
	logic [1:0] rate_next;

	axil_reg_slave #(
		.AW(12)
	) u_bus (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_s_axi_awaddr(i_s_axi_awaddr),
		.i_s_axi_awvalid(i_s_axi_awvalid),
		.o_s_axi_awready(o_s_axi_awready),
		.i_s_axi_wdata(i_s_axi_wdata),
		.i_s_axi_wstrb(i_s_axi_wstrb),
		.i_s_axi_wvalid(i_s_axi_wvalid),
		.o_s_axi_wready(o_s_axi_wready),
		.o_s_axi_bresp(o_s_axi_bresp),
		.o_s_axi_bvalid(o_s_axi_bvalid),
		.i_s_axi_bready(i_s_axi_bready),
		.i_s_axi_araddr(i_s_axi_araddr),
		.i_s_axi_arvalid(i_s_axi_arvalid),
		.o_s_axi_arready(o_s_axi_arready),
		.o_s_axi_rdata(o_s_axi_rdata),
		.o_s_axi_rresp(o_s_axi_rresp),
		.o_s_axi_rvalid(o_s_axi_rvalid),
		.i_s_axi_rready(i_s_axi_rready),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_wr_strb(wr_strb),
		.i_wr_ok(wr_ok),
		.o_rd_en(rd_en),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data),
		.i_rd_ok(rd_ok)
	);

	bit_sync2 #(
		.RESET_VAL(1'b1)
	) u_change_sync (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_async(i_media_changed_pin),
		.o_sync(changed_pin_sync)
	);

	// decode; byte lane 0 carries every register, others are dropped
	assign wr_lane = wr_en && wr_strb[0];
	assign wr_status = wr_lane && wr_addr == fdc_port_pkg::ADDR_STATUS;
	assign wr_data_hit = wr_lane && wr_addr == fdc_port_pkg::ADDR_DATA;
	assign wr_digital = wr_lane && wr_addr == fdc_port_pkg::ADDR_DIGITAL;
	assign wr_ctrl = wr_lane && wr_addr == fdc_port_pkg::ADDR_CTRL;
	assign wr_ok = wr_addr == fdc_port_pkg::ADDR_STATUS
		|| wr_addr == fdc_port_pkg::ADDR_DATA
		|| wr_addr == fdc_port_pkg::ADDR_DIGITAL
		|| wr_addr == fdc_port_pkg::ADDR_CTRL;
	assign rd_status = rd_en && rd_addr == fdc_port_pkg::ADDR_STATUS;
	assign rd_data_hit = rd_en && rd_addr == fdc_port_pkg::ADDR_DATA;
	assign rd_ok = rd_addr == fdc_port_pkg::ADDR_STATUS
		|| rd_addr == fdc_port_pkg::ADDR_DATA
		|| rd_addr == fdc_port_pkg::ADDR_DIGITAL
		|| rd_addr == fdc_port_pkg::ADDR_CTRL;

	assign soft_rst = (wr_status && wr_data[fdc_port_pkg::DSR_SOFT_RESET])
		|| i_dor_reset;
	assign layout = ctrl_reg[fdc_port_pkg::CTL_LAYOUT_LSB +: 2];

	// single-byte depth outside execution keeps commands paced by rqm
	assign limit = (fifo_on_reg && i_exec_phase) ? DEPTH_L : ONE_L;
	assign full = level_reg >= limit;
	assign empty = level_reg == '0;
	assign transfer_direction = i_transfer_direction;
	assign host_transfer_request = transfer_direction ? !empty : (i_core_accept && !full);
	// bytes offered while rqm is low are ignored
	assign host_push = wr_data_hit && host_transfer_request && !transfer_direction;
	assign host_pop = rd_data_hit && host_transfer_request && transfer_direction;
	assign core_push_ok = i_core_push && !full && !host_push;
	assign core_pop_ok = i_core_pop && !empty && !host_pop;
	assign push = host_push || core_push_ok;
	assign pop = host_pop || core_pop_ok;
	assign push_data = host_push ? wr_data[7:0] : i_core_push_data;
	assign flush = soft_rst || i_exec_start;

	// status is built from live state, so a read right after a data
	// access already reflects it
	always_comb begin
		status = 8'h00;
		status[fdc_port_pkg::ST_DRV_A] = i_drive_a_seeking;
		status[fdc_port_pkg::ST_DRV_B] = i_drive_b_seeking;
		status[fdc_port_pkg::ST_CMD_BUSY] = busy_reg;
		status[fdc_port_pkg::ST_DIR] = transfer_direction;
		status[fdc_port_pkg::ST_RQM] = host_transfer_request;
	end

	assign change_bit = ctrl_reg[fdc_port_pkg::CTL_FORCE_EN]
		? ctrl_reg[fdc_port_pkg::CTL_FORCE_VAL]
		: !changed_pin_sync;

	always_comb begin
		case (layout)
		fdc_port_pkg::LAYOUT_EXT: begin
			digital = {change_bit, fdc_port_pkg::EXT_FILL, rate_reg,
				!high_density(rate_reg)};
		end
		fdc_port_pkg::LAYOUT_MIRROR: begin
			digital = {change_bit, 3'h0, i_dma_allow, no_shift_reg,
				rate_reg};
		end
		default: begin
			digital = {change_bit, 7'h00};
		end
		endcase
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
		fdc_port_pkg::ADDR_STATUS: begin
			rd_data[7:0] = status;
		end
		fdc_port_pkg::ADDR_DATA: begin
			rd_data[7:0] = host_pop ? mem[rd_ptr_reg] : 8'h00;
		end
		fdc_port_pkg::ADDR_DIGITAL: begin
			rd_data[7:0] = digital;
		end
		fdc_port_pkg::ADDR_CTRL: begin
			rd_data[3:0] = ctrl_reg;
		end
		default: begin
			rd_data = 32'h0000_0000;
		end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ctrl_reg <= 4'h0;
		end else if (wr_ctrl) begin
			ctrl_reg <= wr_data[3:0];
		end
	end

	// both rate registers feed one store; the newest write wins
	assign rate_write = wr_status || wr_digital;
	assign rate_next = wr_data[1:0];

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rate_reg <= fdc_port_pkg::RATE_RESET;
		end else if (rate_write) begin
			rate_reg <= rate_next;
		end
	end

	// density follows rate writes only; resets from software leave it
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			density_reg <= fdc_port_pkg::DENSITY_RESET;
		end else if (rate_write) begin
			density_reg <= high_density(rate_next);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			precomp_reg <= fdc_port_pkg::PRECOMP_RESET;
		end else if (wr_status) begin
			precomp_reg <= wr_data[fdc_port_pkg::DSR_PRECOMP_LSB +: 3];
		end
	end

	// stored and mirrored only; nothing downstream acts on it
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			no_shift_reg <= 1'b0;
		end else if (wr_digital && layout == fdc_port_pkg::LAYOUT_MIRROR) begin
			no_shift_reg <= wr_data[fdc_port_pkg::CCR_NO_SHIFT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			low_power_reg <= 1'b0;
		end else if (wr_status && wr_data[fdc_port_pkg::DSR_LOW_POWER]
			&& !wr_data[fdc_port_pkg::DSR_SOFT_RESET]) begin
			low_power_reg <= 1'b1;
		end else if (soft_rst || rd_status || rd_data_hit || wr_data_hit) begin
			low_power_reg <= 1'b0;
		end
	end

	// a new command byte outranks an end event in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			busy_reg <= 1'b0;
		end else if (host_push) begin
			busy_reg <= 1'b1;
		end else if (i_cmd_end || soft_rst) begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_rst) begin
			fifo_on_reg <= 1'b0;
			thr_reg <= 4'h0;
		end else if (i_fifo_config) begin
			fifo_on_reg <= i_fifo_enable;
			thr_reg <= i_fifo_threshold;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				level_reg <= level_reg + ONE_L;
			end else if (pop && !push) begin
				level_reg <= level_reg - ONE_L;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (push && !flush) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	// an empty pop hands the core a zero byte to pad the sector
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_rst) begin
			o_core_pop_strobe <= 1'b0;
			o_core_pop_data <= 8'h00;
		end else begin
			o_core_pop_strobe <= i_core_pop;
			o_core_pop_data <= core_pop_ok ? mem[rd_ptr_reg] : 8'h00;
		end
	end

	// fault set beats the clear so a late overrun is still seen
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			fault_reg <= 1'b0;
		end else if ((i_core_push && !core_push_ok)
			|| (i_core_pop && !core_pop_ok)) begin
			fault_reg <= 1'b1;
		end else if (i_cmd_end || soft_rst) begin
			fault_reg <= 1'b0;
		end
	end

	// threshold field holds count minus one
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_service_req <= 1'b0;
		end else begin
			o_service_req <= fifo_on_reg && i_exec_phase && (transfer_direction
				? level_reg > {1'b0, thr_reg}
				: (limit - level_reg) > {1'b0, thr_reg});
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= soft_rst;
		end
	end

	assign o_rate_select = rate_reg;
	assign o_precomp = precomp_reg;
	assign o_no_write_shift = no_shift_reg;
	assign o_low_power = low_power_reg;
	assign o_density_select_pin = density_reg;
	assign o_cmd_busy = busy_reg;
	assign o_fifo_on = fifo_on_reg;
	assign o_fifo_level = level_reg;
	assign o_xfer_fault = fault_reg;
endmodule : floppy_host_status_port

// File: tb/fdc_port_checker.sv
`timescale 1ns/1ns
module fdc_port_checker #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic i_cmd_end,
	input wire logic i_exec_start,
	input wire logic i_core_push,
	input wire logic i_core_pop,
	input wire logic i_dor_reset,
	input wire logic o_core_pop_strobe,
	input wire logic o_xfer_fault,
	input wire logic [$clog2(FIFO_DEPTH):0] o_fifo_level,
	input wire logic o_fifo_on,
	input wire logic o_cmd_busy,
	input wire logic o_soft_reset,
	input wire logic [1:0] o_rate_select,
	input wire logic o_density_select_pin
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	a_read_answer: assert property (
		i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_hold: assert property (
		o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped before taken");
	a_write_hold: assert property (
		o_s_axi_bvalid && !i_s_axi_bready
		|=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped before taken");
	a_upper_zero: assert property (
		o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	a_pop_strobe: assert property (
		i_core_pop && !i_dor_reset |=> o_core_pop_strobe)
		else $error("core pop gave no strobe");
	a_underrun_flag: assert property (
		i_core_pop && !i_core_push && o_fifo_level == 0 && !i_dor_reset
		|=> o_xfer_fault)
		else $error("pop from empty not flagged");
	a_busy_drop: assert property (
		$fell(o_cmd_busy) && !$past(i_srst)
		|-> $past(i_cmd_end) || $past(i_dor_reset) || o_soft_reset)
		else $error("busy dropped without cause");
	a_flush_exec: assert property (
		i_exec_start && !i_core_push |=> o_fifo_level == 0)
		else $error("execution start did not flush");
	a_depth_one: assert property (
		!o_fifo_on |-> o_fifo_level <= 1)
		else $error("fifo deeper than one while off");
	a_density_track: assert property (
		$changed(o_rate_select) && !$past(i_srst)
		|-> o_density_select_pin == (o_rate_select[1] == o_rate_select[0]))
		else $error("density pin does not match rate");
	a_hard_reset: assert property (
		$fell(i_srst) |-> o_density_select_pin && o_rate_select == 2'h2
		&& !o_fifo_on && !o_cmd_busy)
		else $error("wrong state after hard reset");
	a_soft_pulse: assert property (
		o_soft_reset |=> !o_soft_reset)
		else $error("soft reset pulse too long");
endmodule : fdc_port_checker

bind floppy_host_status_port fdc_port_checker #(
	.FIFO_DEPTH(FIFO_DEPTH)
) u_checker (.*);

// File: tb/host_axil_master.sv
`timescale 1ns/1ns
module host_axil_master (
	input wire logic i_mclk,
	output logic [11:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	output logic o_bready,
	output logic [11:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic o_rready
);
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
		o_wstrb = 4'hF;
	end
	// released payload is inverted so a late sample cannot match
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		output logic [1:0] r);
		bit dn = 0;
		@(posedge i_mclk);
		o_awaddr <= a;
		o_wdata <= {24'h0, d};
		o_awvalid <= 1'h1;
		o_wvalid <= 1'h1;
		o_bready <= 1'h1;
		while (!dn) begin
			@(posedge i_mclk);
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'h0;
				o_awaddr <= ~a;
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'h0;
				o_wdata <= ~{24'h0, d};
			end
			if (i_bvalid) begin
				r = i_bresp;
				o_bready <= 1'h0;
				dn = 1;
			end
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] v,
		output logic [1:0] r);
		bit dn = 0;
		@(posedge i_mclk);
		o_araddr <= a;
		o_arvalid <= 1'h1;
		o_rready <= 1'h1;
		while (!dn) begin
			@(posedge i_mclk);
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'h0;
				o_araddr <= ~a;
			end
			if (i_rvalid) begin
				v = i_rdata;
				r = i_rresp;
				o_rready <= 1'h0;
				dn = 1;
			end
		end
	endtask : rd
endmodule : host_axil_master

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam logic [11:0] A_ST = fdc_port_pkg::ADDR_STATUS;
	localparam logic [11:0] A_DT = fdc_port_pkg::ADDR_DATA;
	localparam logic [11:0] A_DI = fdc_port_pkg::ADDR_DIGITAL;
	localparam logic [11:0] A_CT = fdc_port_pkg::ADDR_CTRL;
	logic i_mclk, i_srst;
	logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb, i_fifo_threshold;
	logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_rate_select, resp;
	logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready;
	logic o_s_axi_rvalid, i_s_axi_rready, i_media_changed_pin;
	logic i_drive_a_seeking, i_drive_b_seeking, i_transfer_direction;
	logic i_core_accept, i_cmd_end, i_exec_start, i_exec_phase;
	logic i_fifo_config, i_fifo_enable, i_core_push, i_core_pop;
	logic [7:0] i_core_push_data, o_core_pop_data, v;
	logic i_dor_reset, i_dma_allow, o_core_pop_strobe, o_xfer_fault;
	logic [4:0] o_fifo_level;
	logic o_fifo_on, o_service_req, o_cmd_busy, o_soft_reset;
	logic [2:0] o_precomp;
	logic o_no_write_shift, o_low_power, o_density_select_pin;
	logic [31:0] rdv;
	logic [7:0] q[$];
	integer seed;
	int fails, cmp_count;

	always #50 i_mclk = ~i_mclk;
	floppy_host_status_port #(.FIFO_DEPTH(16)) u_dut (.*);
	host_axil_master u_host (.i_mclk(i_mclk),
		.o_awaddr(i_s_axi_awaddr), .o_awvalid(i_s_axi_awvalid),
		.i_awready(o_s_axi_awready), .o_wdata(i_s_axi_wdata),
		.o_wstrb(i_s_axi_wstrb), .o_wvalid(i_s_axi_wvalid),
		.i_wready(o_s_axi_wready), .i_bresp(o_s_axi_bresp),
		.i_bvalid(o_s_axi_bvalid), .o_bready(i_s_axi_bready),
		.o_araddr(i_s_axi_araddr), .o_arvalid(i_s_axi_arvalid),
		.i_arready(o_s_axi_arready), .i_rdata(o_s_axi_rdata),
		.i_rresp(o_s_axi_rresp), .i_rvalid(o_s_axi_rvalid),
		.o_rready(i_s_axi_rready));

	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		u_host.wr(a, d, resp);
		chk("bresp", 32'(resp), 32'(fdc_port_pkg::RESP_OKAY));
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		u_host.rd(a, rdv, resp);
		chk($sformatf("read %h", a), rdv, {24'h0, e});
	endtask : rd
	// bits: config, exec start, cmd end, push, pop
	task automatic core(input logic [4:0] m);
		@(posedge i_mclk);
		{i_fifo_config, i_exec_start, i_cmd_end, i_core_push, i_core_pop} <= m;
		@(posedge i_mclk);
		{i_fifo_config, i_exec_start, i_cmd_end, i_core_push, i_core_pop} <= '0;
		#1;
	endtask : core
	function automatic logic [7:0] st(input logic busy);
		logic host_transfer_request;
		host_transfer_request = i_transfer_direction ? 1'h0 : i_core_accept;
		return {host_transfer_request, i_transfer_direction, 1'h0, busy, 2'h0,
			i_drive_b_seeking, i_drive_a_seeking};
	endfunction : st
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		complete_run();
	end

	initial begin
		seed = 59;
		i_mclk = 1'h0;
		i_srst = 1'h1;
		{i_media_changed_pin, i_drive_a_seeking, i_drive_b_seeking} = '0;
		{i_transfer_direction, i_core_accept, i_exec_phase} = '0;
		{i_fifo_config, i_exec_start, i_cmd_end, i_core_push} = '0;
		{i_core_pop, i_fifo_enable, i_dor_reset, i_dma_allow} = '0;
		i_fifo_threshold = 4'h0;
		i_core_push_data = 8'h00;
		repeat (6) @(posedge i_mclk);
		i_srst <= 1'h0;
		chk("fifo on", 32'(o_fifo_on), 32'h0);
		// change pin needs two edges through its synchroniser
		repeat (2) @(posedge i_mclk);
		rd(A_DI, 8'h80);
		for (int k = 0; k < 8; k++) begin
			@(posedge i_mclk);
			{i_drive_a_seeking, i_drive_b_seeking, i_transfer_direction,
				i_core_accept} <= 4'($random(seed));
			@(posedge i_mclk);
			rd(A_ST, st(1'h0));
		end
		u_host.rd(12'h000, rdv, resp);
		chk("unmapped", 32'(resp), 32'(fdc_port_pkg::RESP_SLVERR));
		$display("test status done");
		{i_drive_a_seeking, i_drive_b_seeking, i_transfer_direction,
			i_core_accept} <= 4'h1;
		rd(A_ST, 8'h80);
		wr(A_DT, 8'h03);
		rd(A_ST, 8'h10);
		wr(A_DT, 8'h55);
		core(5'h01);
		chk("pop data", 32'(o_core_pop_data), 32'h03);
		core(5'h01);
		chk("underrun", {o_core_pop_data, o_xfer_fault}, 9'h001);
		core(5'h04);
		chk("busy", {o_cmd_busy, o_xfer_fault}, 2'h0);
		i_transfer_direction <= 1'h1;
		i_core_push_data <= 8'hC5;
		core(5'h02);
		rd(A_ST, 8'hC0);
		rd(A_DT, 8'hC5);
		rd(A_ST, 8'h40);
		$display("test handshake done");
		i_fifo_enable <= 1'h1;
		i_fifo_threshold <= 4'h3;
		i_exec_phase <= 1'h1;
		core(5'h10);
		for (int k = 0; k < 4; k++) begin
			v = 8'($random(seed));
			q.push_back(v);
			i_core_push_data <= v;
			core(5'h02);
		end
		// service request flop lags the level by one edge
		@(posedge i_mclk);
		#1;
		chk("service", {o_fifo_on, o_service_req, o_fifo_level}, 7'h64);
		for (int k = 0; k < 4; k++) begin
			rd(A_ST, 8'hC0);
			rd(A_DT, q.pop_front());
		end
		core(5'h02);
		core(5'h08);
		chk("flush", {o_service_req, o_fifo_level}, 6'h00);
		i_exec_phase <= 1'h0;
		$display("test fifo done");
		wr(A_CT, 8'h01);
		for (int r = 0; r < 4; r++) begin
			wr(A_DI, 8'(r));
			rd(A_DI, {5'h1F, 2'(r), 1'(r == 1 || r == 2)});
			chk("density", 32'(o_density_select_pin), 32'(r == 0 || r == 3));
		end
		i_dma_allow <= 1'h1;
		wr(A_CT, 8'h02);
		wr(A_DI, 8'h06);
		rd(A_DI, 8'h8E);
		wr(A_CT, 8'h06);
		rd(A_DI, 8'h0E);
		wr(A_ST, 8'h01);
		chk("rate", 32'(o_rate_select), 32'h1);
		wr(A_DI, 8'h06);
		chk("rate", 32'(o_rate_select), 32'h2);
		wr(A_ST, 8'h81);
		chk("soft", {o_rate_select, o_no_write_shift, o_fifo_on}, 4'h6);
		// reset from the output register leaves rate and density alone
		i_dor_reset <= 1'h1;
		@(posedge i_mclk);
		i_dor_reset <= 1'h0;
		@(posedge i_mclk);
		chk("hold", {o_rate_select, o_density_select_pin}, 3'h2);
		wr(A_ST, 8'h46);
		chk("dsr", {o_low_power, o_precomp, o_rate_select}, 6'h26);
		rd(A_ST, 8'h40);
		chk("wake", 32'(o_low_power), 32'h0);
		$display("test rate done");
		wr(A_DI, 8'h01);
		@(posedge i_mclk);
		i_srst <= 1'h1;
		repeat (3) @(posedge i_mclk);
		i_srst <= 1'h0;
		chk("hard", {o_rate_select, o_density_select_pin}, 3'h5);
		repeat (2) @(posedge i_mclk);
		rd(A_DI, 8'h80);
		$display("test reset done");
		complete_run();
	end
endmodule : testbench
